// file: core/esr_pkg.sv
/*
 * Constants and types for the sequential-read serial memory target.
 * Assumes a 200 MHz core clock and a two-wire bus sampled through filters.
 */
package esr_pkg;
    localparam int CLK_NS = 5;
    localparam int FILT_NS_DEF = 50;
    localparam int POR_NS = 1000;
    localparam int POR_CYC = (POR_NS + CLK_NS - 1) / CLK_NS;
    localparam int POR_CNT_W = 8;
    localparam int ADDR_W = 16;
    localparam int BYTE_W = 8;
    localparam int MEM_WORDS = 1 << ADDR_W;
    localparam int PAGE_BITS = 7;
    localparam int FIFO_DEPTH = 8;
    localparam int SEL_W = 3;
    localparam int BIT_CNT_W = 4;
    localparam logic [BIT_CNT_W-1:0] BITS_PER_BYTE = 4'h8;
    localparam logic [BIT_CNT_W-1:0] LAST_BIT = 4'h7;
    localparam int DEVB_TYPE_LSB = 4;
    localparam int DEVB_SEL_LSB = 1;
    localparam int DEVB_RW_BIT = 0;
    // arbitrary type code value, not tied to any real part
    localparam logic [3:0] DEV_TYPE = 4'h5;
    localparam logic [BYTE_W-1:0] EMPTY_BYTE = 8'hff;
    localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;

    typedef enum {ST_IDLE, ST_DEV, ST_MAH, ST_MAL, ST_WR, ST_RD, ST_RACK, ST_WSTOP} esr_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } esr_lines_t;

    typedef struct packed {
        logic en;
        logic [ADDR_W-1:0] addr;
        logic [BYTE_W-1:0] data;
    } esr_load_t;
endpackage

// file: core/esr_filt.sv
/*
 * Two-flop synchroniser followed by a stability filter for one bus line.
 * Assumes the input is asynchronous to clk and idles high.
 */
`timescale 1ns/1ps
`default_nettype none
module esr_filt #(
    parameter int CYC = 10
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic din,
    output logic dout
);
    localparam int CW = $clog2(CYC + 1) + 1;
    logic s1_r;
    logic s2_r;
    logic [CW-1:0] cnt_r;
    wire differ = s2_r != dout;
    wire settled = cnt_r == CW'(CYC - 1);

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
        end
        else
        begin
            s1_r <= din;
            s2_r <= s1_r;
        end
    end

    // a level must hold CYC cycles before it passes; shorter pulses vanish
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cnt_r <= '0;
            dout <= 1'b1;
        end
        else if (!differ)
            cnt_r <= '0;
        else if (settled)
        begin
            cnt_r <= '0;
            dout <= s2_r;
        end
        else
            cnt_r <= cnt_r + CW'(1);
    end
endmodule
`default_nettype wire

// file: core/esr_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides and a flush.
 * Assumes one clock; flush wins over a push in the same cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module esr_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    wire [AW-1:0] wp_inc = (wp_r == AW'(D - 1)) ? '0 : wp_r + AW'(1);
    wire [AW-1:0] rp_inc = (rp_r == AW'(D - 1)) ? '0 : rp_r + AW'(1);

    assign in_ready = cnt_r != (AW + 1)'(D);
    assign out_valid = cnt_r != '0;
    assign out_data = mem[rp_r];

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wp_r] <= in_data;
    end

    always_ff @(posedge clk)
    begin
        if (srst || flush)
        begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            if (push)
                wp_r <= wp_inc;
            if (pop)
                rp_r <= rp_inc;
            cnt_r <= cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
endmodule
`default_nettype wire

// file: core/esr_seq_read.sv
/*
 * Two-wire serial memory target: addressing, dummy write, current and
 * sequential reads with a prefetch FIFO, power-on guard and line filters.
 * Assumes SCL and SDA_I arrive asynchronously; SDA is open drain outside.
 */
`timescale 1ns/1ps
`default_nettype none
module esr_seq_read
    import esr_pkg::*;
#(
    parameter int FILT_NS = FILT_NS_DEF
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic SCL,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE,
    input wire logic [SEL_W-1:0] CHIP_SELECT_STRAPS,
    input wire logic WRITE_GUARD,
    input wire esr_load_t LOAD
);
    localparam int FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;

    esr_lines_t ln;
    esr_lines_t ln_prev_r;
    esr_state_t st_r;
    esr_state_t st_nxt;
    esr_state_t go_r;
    esr_state_t go_nxt;
    logic [BIT_CNT_W-1:0] cnt_r;
    logic [BIT_CNT_W-1:0] cnt_nxt;
    logic [BYTE_W-1:0] sh_r;
    logic [BYTE_W-1:0] sh_nxt;
    logic [BYTE_W-1:0] hi_r;
    logic [BYTE_W-1:0] hi_nxt;
    logic [ADDR_W-1:0] cur_addr_r;
    logic [ADDR_W-1:0] cur_addr_nxt;
    logic [ADDR_W-1:0] fetch_addr_r;
    logic ack_slot_r;
    logic ack_slot_nxt;
    logic oe_nxt;
    logic mack_r;
    logic mack_nxt;
    logic fetch_en_r;
    logic fetch_en_nxt;
    logic fetch_arm;
    logic pop;
    logic mem_we;
    logic [SEL_W-1:0] sel_s1_r;
    logic [SEL_W-1:0] sel_r;
    logic wg_s1_r;
    logic wg_r;
    logic [POR_CNT_W-1:0] por_cnt_r;
    logic por_ok_r;
    logic [BYTE_W-1:0] mem [MEM_WORDS];
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [BYTE_W-1:0] fifo_out_data;

    esr_filt #(.CYC(FILT_CYC)) u_filt_scl (
        .clk(CLK),
        .srst(SRST),
        .din(SCL),
        .dout(ln.scl)
    );

    esr_filt #(.CYC(FILT_CYC)) u_filt_sda (
        .clk(CLK),
        .srst(SRST),
        .din(SDA_I),
        .dout(ln.sda)
    );

    wire scl_rise = ln.scl && !ln_prev_r.scl;
    wire scl_fall = !ln.scl && ln_prev_r.scl;
    wire scl_hold = ln.scl && ln_prev_r.scl;
    wire bus_start = scl_hold && ln_prev_r.sda && !ln.sda;
    wire bus_stop = scl_hold && !ln_prev_r.sda && ln.sda;
    wire byte_done = scl_fall && !ack_slot_r && (cnt_r == BITS_PER_BYTE);
    wire ack_end = scl_fall && ack_slot_r;
    wire dev_match = (sh_r[BYTE_W-1:DEVB_TYPE_LSB] == DEV_TYPE)
        && (sh_r[DEVB_TYPE_LSB-1:DEVB_SEL_LSB] == sel_r);
    wire dev_read = sh_r[DEVB_RW_BIT];
    wire [BYTE_W-1:0] next_byte = fifo_out_valid ? fifo_out_data : EMPTY_BYTE;
    wire push = fetch_en_r && fifo_in_ready;
    wire fifo_flush = bus_start || bus_stop;
    wire [ADDR_W-1:0] cur_inc = cur_addr_r + ADDR_W'(1);
    wire [PAGE_BITS-1:0] page_inc = cur_addr_r[PAGE_BITS-1:0] + PAGE_BITS'(1);
    wire lines_still = ln == ln_prev_r;

    // prefetched bytes sit here; a full FIFO stalls the fetch pointer
    esr_fifo #(.W(BYTE_W), .D(FIFO_DEPTH)) u_fifo (
        .clk(CLK),
        .srst(SRST),
        .flush(fifo_flush),
        .in_valid(fetch_en_r),
        .in_ready(fifo_in_ready),
        .in_data(mem[fetch_addr_r]),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(fifo_out_data)
    );

    // straps are pins; open pins are expected pulled down at the pad
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            sel_s1_r <= '0;
            sel_r <= '0;
            wg_s1_r <= 1'b0;
            wg_r <= 1'b0;
        end
        else
        begin
            sel_s1_r <= CHIP_SELECT_STRAPS;
            sel_r <= sel_s1_r;
            wg_s1_r <= WRITE_GUARD;
            wg_r <= wg_s1_r;
        end
    end

    // any wiggle restarts the wait, so ramp noise never opens a transfer
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            por_cnt_r <= '0;
            por_ok_r <= 1'b0;
        end
        else if (!por_ok_r)
        begin
            if (!lines_still)
                por_cnt_r <= '0;
            else if (por_cnt_r == POR_CNT_W'(POR_CYC))
                por_ok_r <= 1'b1;
            else
                por_cnt_r <= por_cnt_r + POR_CNT_W'(1);
        end
    end

    always_comb
    begin
        st_nxt = st_r;
        go_nxt = go_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        hi_nxt = hi_r;
        cur_addr_nxt = cur_addr_r;
        ack_slot_nxt = ack_slot_r;
        oe_nxt = SDA_OE;
        mack_nxt = mack_r;
        fetch_en_nxt = fetch_en_r;
        fetch_arm = 1'b0;
        pop = 1'b0;
        mem_we = 1'b0;
        if (bus_stop)
        begin
            st_nxt = ST_IDLE;
            oe_nxt = 1'b0;
            ack_slot_nxt = 1'b0;
            fetch_en_nxt = 1'b0;
        end
        else if (bus_start && por_ok_r)
        begin
            st_nxt = ST_DEV;
            cnt_nxt = '0;
            oe_nxt = 1'b0;
            ack_slot_nxt = 1'b0;
            fetch_en_nxt = 1'b0;
        end
        else
        begin
            case (st_r)
                ST_DEV, ST_MAH, ST_MAL, ST_WR:
                begin
                    if (scl_rise && !ack_slot_r)
                    begin
                        sh_nxt = {sh_r[BYTE_W-2:0], ln.sda};
                        cnt_nxt = cnt_r + BIT_CNT_W'(1);
                    end
                    else if (byte_done)
                    begin
                        cnt_nxt = '0;
                        ack_slot_nxt = 1'b1;
                        oe_nxt = 1'b1;
                        case (st_r)
                            ST_DEV:
                            begin
                                if (!dev_match)
                                begin
                                    st_nxt = ST_IDLE;
                                    ack_slot_nxt = 1'b0;
                                    oe_nxt = 1'b0;
                                end
                                else if (dev_read)
                                begin
                                    go_nxt = ST_RD;
                                    fetch_arm = 1'b1;
                                    fetch_en_nxt = 1'b1;
                                end
                                else
                                    go_nxt = ST_MAH;
                            end
                            ST_MAH:
                                go_nxt = ST_MAL;
                            ST_MAL:
                                go_nxt = ST_WR;
                            ST_WR:
                            begin
                                oe_nxt = !wg_r;
                                go_nxt = wg_r ? ST_IDLE : ST_WR;
                            end
                            default:
                                go_nxt = ST_IDLE;
                        endcase
                    end
                    else if (ack_end)
                    begin
                        ack_slot_nxt = 1'b0;
                        oe_nxt = 1'b0;
                        cnt_nxt = '0;
                        st_nxt = go_r;
                        if (st_r == ST_MAH)
                            hi_nxt = sh_r;
                        if (st_r == ST_MAL)
                            cur_addr_nxt = {hi_r, sh_r};
                        if (st_r == ST_WR && go_r == ST_WR)
                        begin
                            mem_we = 1'b1;
                            cur_addr_nxt = {cur_addr_r[ADDR_W-1:PAGE_BITS], page_inc};
                        end
                        if (go_r == ST_RD)
                        begin
                            pop = 1'b1;
                            sh_nxt = next_byte;
                            oe_nxt = !next_byte[BYTE_W-1];
                        end
                    end
                end
                ST_RD:
                begin
                    if (scl_fall)
                    begin
                        if (cnt_r == LAST_BIT)
                        begin
                            oe_nxt = 1'b0;
                            st_nxt = ST_RACK;
                        end
                        else
                        begin
                            sh_nxt = {sh_r[BYTE_W-2:0], 1'b0};
                            oe_nxt = !sh_r[BYTE_W-2];
                            cnt_nxt = cnt_r + BIT_CNT_W'(1);
                        end
                    end
                end
                ST_RACK:
                begin
                    if (scl_rise)
                        mack_nxt = ln.sda;
                    else if (scl_fall)
                    begin
                        // wraps from all ones to zero by plain overflow
                        cur_addr_nxt = cur_inc;
                        cnt_nxt = '0;
                        if (!mack_r)
                        begin
                            pop = 1'b1;
                            sh_nxt = next_byte;
                            oe_nxt = !next_byte[BYTE_W-1];
                            st_nxt = ST_RD;
                        end
                        else
                        begin
                            st_nxt = ST_WSTOP;
                            fetch_en_nxt = 1'b0;
                        end
                    end
                end
                ST_WSTOP, ST_IDLE:
                    oe_nxt = 1'b0;
                default:
                begin
                    st_nxt = ST_IDLE;
                    oe_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            st_r <= ST_IDLE;
            go_r <= ST_IDLE;
            cnt_r <= '0;
            sh_r <= '0;
            hi_r <= '0;
            cur_addr_r <= ADDR_RST;
            ack_slot_r <= 1'b0;
            mack_r <= 1'b1;
            fetch_en_r <= 1'b0;
            SDA_OE <= 1'b0;
            SDA_O <= 1'b0;
            ln_prev_r <= '1;
        end
        else
        begin
            st_r <= st_nxt;
            go_r <= go_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            hi_r <= hi_nxt;
            cur_addr_r <= cur_addr_nxt;
            ack_slot_r <= ack_slot_nxt;
            mack_r <= mack_nxt;
            fetch_en_r <= fetch_en_nxt;
            SDA_OE <= oe_nxt;
            SDA_O <= 1'b0;
            ln_prev_r <= ln;
        end
    end

    // fetch runs ahead of the shifter; the FIFO flush on start/stop drops
    // the surplus, and cur_addr_r alone remembers where reading stopped
    always_ff @(posedge CLK)
    begin
        if (SRST)
            fetch_addr_r <= ADDR_RST;
        else if (fetch_arm)
            fetch_addr_r <= cur_addr_r;
        else if (push)
            fetch_addr_r <= fetch_addr_r + ADDR_W'(1);
    end

    // the load port wins over a bus write in the same cycle
    always_ff @(posedge CLK)
    begin
        if (LOAD.en)
            mem[LOAD.addr] <= LOAD.data;
        else if (mem_we)
            mem[cur_addr_r] <= sh_r;
    end
endmodule
`default_nettype wire

// file: verification/esr_seq_read_properties.sv
/*
 * Pin-level assertions for the sequential-read target.
 * Assumes the bus idles high and the bench resolves the open-drain wire.
 */
`timescale 1ns/1ps
`default_nettype none
module esr_seq_read_chk
    import esr_pkg::*;
#(
    parameter int FILT_NS = FILT_NS_DEF
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic SCL,
    input wire logic SDA_I,
    input wire logic SDA_O,
    input wire logic SDA_OE,
    input wire logic [SEL_W-1:0] CHIP_SELECT_STRAPS,
    input wire logic WRITE_GUARD,
    input wire esr_load_t LOAD
);
    localparam int FC = FILT_NS / CLK_NS;
    logic [7:0] por_r;
    logic [3:0] low_r;
    logic scl_q;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SRST);
    always_ff @(posedge CLK)
    begin
        scl_q <= SCL;
        if (SRST)
            por_r <= 8'h00;
        else if (por_r != 8'hff)
            por_r <= por_r + 8'h01;
        // a one-sample pulse must not restart the low-phase count
        if (SRST || (SCL && scl_q))
            low_r <= 4'h0;
        else if (low_r != 4'hf)
            low_r <= low_r + 4'h1;
    end
    sequence s_start;
        SCL && $fell(SDA_I);
    endsequence
    sequence s_stop;
        SCL && $rose(SDA_I);
    endsequence
    sequence s_high3;
        $rose(SCL) ##1 SCL [*2];
    endsequence
    a_sda_o_zero: assert property (SDA_O == 1'b0) else $error("data output value not low");
    a_por_quiet: assert property (por_r < 8'hc8 |-> !SDA_OE) else $error("bus driven during power-on guard");
    a_oe_scl_low: assert property ($changed(SDA_OE) |-> !SCL) else $error("data changed while clock high");
    a_oe_late_fall: assert property ($changed(SDA_OE) |-> low_r > FC) else $error("data changed before filtered fall");
    a_oe_high_hold: assert property (s_high3 |=> $stable(SDA_OE) [*5]) else $error("data moved in clock high");
    a_oe_min_width: assert property ($changed(SDA_OE) |=> $stable(SDA_OE) [*8]) else $error("data bit too short");
    a_start_quiet: assert property (s_start |=> !SDA_OE [*8]) else $error("driven right after start");
    a_stop_release: assert property (s_stop |=> !SDA_OE [*8]) else $error("driven after stop");
endmodule
bind esr_seq_read esr_seq_read_chk #(.FILT_NS(FILT_NS)) i_chk (.CLK(CLK), .SRST(SRST), .SCL(SCL), .SDA_I(SDA_I),
    .SDA_O(SDA_O), .SDA_OE(SDA_OE), .CHIP_SELECT_STRAPS(CHIP_SELECT_STRAPS), .WRITE_GUARD(WRITE_GUARD), .LOAD(LOAD));
`default_nettype wire

// file: verification/esr_ctrl_model.sv
/*
 * Behavioural two-wire bus controller: start, stop, bits and bytes.
 * Assumes the bench resolves the open-drain data wire; 80 ns bus clock.
 */
`timescale 1ns/1ps
`default_nettype none
module esr_ctrl_model (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_oe
);
    int stretch = 0;
    bit glitch = 0;
    initial
    begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    task automatic start();
        @(negedge clk);
        #10 sda_oe = 1'b0;
        #30 scl = 1'b1;
        #40 sda_oe = 1'b1;
        #40 scl = 1'b0;
    endtask
    task automatic stop();
        @(negedge clk);
        #10 sda_oe = 1'b1;
        #30 scl = 1'b1;
        #40 sda_oe = 1'b0;
        #40;
    endtask
    // stretch holds the clock low, which is how a slow controller stalls
    task automatic bitx(input logic b, output logic s);
        #10 sda_oe = !b;
        if (glitch)
        begin
            #5 scl = 1'b1;
            #5 scl = 1'b0;
            #(20 + stretch);
        end
        else
            #(30 + stretch);
        scl = 1'b1;
        #30 s = sda;
        #10 scl = 1'b0;
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bitx(b[i], s);
        bitx(1'b1, ack);
    endtask
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            bitx(1'b1, d[i]);
        bitx(last, s);
    endtask
endmodule
`default_nettype wire

// file: verification/esr_seq_read_tb_top.sv
/*
 * Self-checking bench: controller model on the bus, array filled
 * through the load port. Assumes the filter parameter is set for 10 ns.
 */
`timescale 1ns/1ps
`default_nettype none
module esr_seq_read_tb_top
    import esr_pkg::*;
;
    logic CLK = 1'b0;
    logic SRST = 1'b1;
    logic guard = 1'b0;
    logic [SEL_W-1:0] straps = 3'h0;
    esr_load_t load = '0;
    wire logic scl;
    wire logic m_oe;
    wire logic dev_o;
    wire logic dev_oe;
    wire logic sda_w;
    int fail_count = 0;
    int compares = 0;
    // the device pulls low only when it enables its driver with a low value
    assign sda_w = !(m_oe | (dev_oe & !dev_o));
    esr_seq_read #(.FILT_NS(10)) i_dut (.CLK(CLK), .SRST(SRST), .SCL(scl), .SDA_I(sda_w), .SDA_O(dev_o),
        .SDA_OE(dev_oe), .CHIP_SELECT_STRAPS(straps), .WRITE_GUARD(guard), .LOAD(load));
    esr_ctrl_model i_ctrl (.clk(CLK), .sda(sda_w), .scl(scl), .sda_oe(m_oe));
    initial
    begin
        forever #2.5 CLK = ~CLK;
    end
    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction
    function automatic logic [7:0] dbyte(input logic [2:0] s, input logic rw);
        return {DEV_TYPE, s, rw};
    endfunction
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
            fail_count++;
        end
    endtask
    task automatic finish_test();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic fill(input logic [15:0] a, input int n);
        for (int i = 0; i < n; i++)
        begin
            @(negedge CLK);
            load = '{en: 1'b1, addr: a + 16'(i), data: pat(a + 16'(i))};
        end
        @(negedge CLK);
        load.en = 1'b0;
    endtask
    task automatic addr_set(input logic [15:0] a);
        logic ack;
        i_ctrl.start();
        i_ctrl.wbyte(dbyte(straps, 1'b0), ack);
        chk("dummy write ack", 8'(ack), 8'h00);
        i_ctrl.wbyte(a[15:8], ack);
        chk("addr hi ack", 8'(ack), 8'h00);
        i_ctrl.wbyte(a[7:0], ack);
        chk("addr lo ack", 8'(ack), 8'h00);
    endtask
    task automatic rd(input logic [15:0] a, input int n);
        logic ack;
        logic [7:0] d;
        i_ctrl.start();
        i_ctrl.wbyte(dbyte(straps, 1'b1), ack);
        chk("read ack", 8'(ack), 8'h00);
        for (int i = 0; i < n; i++)
        begin
            i_ctrl.rbyte(i == n - 1, d);
            chk("read data", d, pat(a + 16'(i)));
        end
        i_ctrl.stop();
        chk("released after stop", 8'(dev_oe), 8'h00);
        chk("data out level", 8'(dev_o), 8'h00);
    endtask
    task automatic t_por();
        logic ack;
        i_ctrl.start();
        i_ctrl.wbyte(dbyte(straps, 1'b1), ack);
        chk("early start ack", 8'(ack), 8'h01);
        i_ctrl.stop();
        // lines must stay steady for the guard to expire
        repeat (300) @(negedge CLK);
        $display("test por done");
    endtask
    task automatic t_select();
        logic ack;
        logic [7:0] d;
        for (int p = 0; p < 2; p++)
        begin
            straps = (p == 0) ? 3'h0 : 3'h5;
            repeat (4) @(negedge CLK);
            for (int s = 0; s < 9; s++)
            begin
                i_ctrl.start();
                i_ctrl.wbyte((s == 8) ? {~DEV_TYPE, straps, 1'b1} : dbyte(3'(s), 1'b1), ack);
                chk("select ack", 8'(ack), 8'((s == 8) || (3'(s) != straps)));
                if (ack === 1'b0)
                    i_ctrl.rbyte(1'b1, d);
                i_ctrl.stop();
            end
        end
        $display("test select done");
    endtask
    task automatic t_seq();
        addr_set(16'h1230);
        i_ctrl.stretch = 40;
        rd(16'h1230, 11);
        i_ctrl.stretch = 0;
        rd(16'h123b, 3);
        $display("test sequential done");
    endtask
    task automatic t_wrap();
        addr_set(16'hfffd);
        rd(16'hfffd, 5);
        $display("test wrap done");
    endtask
    task automatic t_guard();
        logic ack;
        guard = 1'b1;
        addr_set(16'h0010);
        i_ctrl.wbyte(8'ha5, ack);
        chk("guarded write ack", 8'(ack), 8'h01);
        i_ctrl.stop();
        guard = 1'b0;
        addr_set(16'h0010);
        rd(16'h0010, 1);
        $display("test guard done");
    endtask
    task automatic t_glitch();
        i_ctrl.glitch = 1'b1;
        addr_set(16'h0000);
        rd(16'h0000, 3);
        i_ctrl.glitch = 1'b0;
        $display("test glitch done");
    endtask
    initial
    begin
        repeat (3) @(negedge CLK);
        SRST = 1'b0;
        repeat (20) @(negedge CLK);
        t_por();
        fill(16'h1230, 16);
        fill(16'hfffd, 7);
        fill(16'h0010, 1);
        t_select();
        t_seq();
        t_wrap();
        t_guard();
        t_glitch();
        finish_test();
    end
    initial
    begin
        repeat (100000) @(posedge CLK);
        fail_count++;
        finish_test();
    end
endmodule
`default_nettype wire
